// >>> inc/link_tx_pkg.sv
package link_tx_pkg;

    // Register byte addresses.
    localparam logic [7:0] ADDR_FMT  = 8'h14;
    localparam logic [7:0] ADDR_LANE = 8'h5F;
    localparam logic [7:0] ADDR_DID  = 8'h64;
    localparam logic [7:0] ADDR_BID  = 8'h65;
    localparam logic [7:0] ADDR_LID  = 8'h67;
    localparam logic [7:0] ADDR_SCR  = 8'h6E;
    localparam logic [7:0] ADDR_F    = 8'h6F;
    localparam logic [7:0] ADDR_K    = 8'h70;
    localparam logic [7:0] ADDR_M    = 8'h71;
    localparam logic [7:0] ADDR_CSN  = 8'h72;
    localparam logic [7:0] ADDR_NP   = 8'h73;
    localparam logic [7:0] ADDR_S    = 8'h74;
    localparam logic [7:0] ADDR_HDCF = 8'h75;
    localparam logic [7:0] ADDR_FCHK = 8'h79;

    // Field positions.
    localparam int LANE_DIS_BIT  = 0;
    localparam int LANE_RAND_BIT = 6;
    localparam int ILAS_LSB      = 2;
    localparam int SCR_BIT       = 7;
    localparam int CS_LSB        = 6;
    localparam int FILL_LSB      = 5;

    // Values after reset.
    localparam logic [7:0] RST_FMT  = 8'h00;
    localparam logic [7:0] RST_LANE = 8'h00;
    localparam logic [7:0] RST_DID  = 8'h00;
    localparam logic [3:0] RST_BID  = 4'h0;
    localparam logic [4:0] RST_LID  = 5'h00;
    localparam logic       RST_SCR  = 1'b1;
    localparam logic [7:0] RST_K    = 8'h1F;
    localparam logic [1:0] RST_CS   = 2'h0;

    // ILAS mode field encodings.
    localparam logic [1:0] ILAS_ON     = 2'h0;
    localparam logic [1:0] ILAS_OFF    = 2'h1;
    localparam logic [1:0] ILAS_REPEAT = 2'h2;

    // Fixed link parameters as reported, and as sent in ILAS (value minus one).
    localparam logic [7:0] L_VAL = 8'h01;
    localparam logic [7:0] F_VAL = 8'h02;
    localparam logic [7:0] M_VAL = 8'h01;
    localparam logic [7:0] S_VAL = 8'h01;
    localparam logic [7:0] N_VAL = 8'h0B;
    localparam logic [7:0] NP_ENC = 8'h0F;
    localparam logic [7:0] CF_VAL = 8'h00;
    localparam logic [7:0] HD_VAL = 8'h00;
    localparam logic [7:0] SUBCLASS = 8'h01;
    localparam logic [7:0] JESDV    = 8'h01;
    localparam int         ILAS_MFS = 4;
    localparam int         CFG_OCTETS = 14;

    // Control characters and the data octets they replace.
    localparam logic [7:0] K28_0 = 8'h1C;
    localparam logic [7:0] K28_3 = 8'h7C;
    localparam logic [7:0] K28_4 = 8'h9C;
    localparam logic [7:0] K28_5 = 8'hBC;
    localparam logic [7:0] K28_7 = 8'hFC;
    localparam logic [14:0] PRN_SEED = 15'h7FFF;

    typedef enum logic [1:0] { PH_OFF, PH_CGS, PH_ILAS, PH_DATA } phase_t;

    typedef struct packed {
        logic [1:0]  ctrl;
        logic [10:0] data;
    } sample_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage : link_tx_pkg

// >>> hdl/link_tx_framer.sv
`timescale 1ns/1ps

// Sample FIFO with first-word-fall-through output.
module sample_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,   // System clock.
    input  wire logic             srst,      // Synchronous reset.
    input  wire logic             ce,        // Clock enable.
    input  wire logic             in_valid,  // Write request.
    input  wire logic [WIDTH-1:0] in_data,   // Write data.
    output logic                  in_ready_q, // Space available.
    output logic                  out_valid, // Head valid.
    output logic      [WIDTH-1:0] out_data,  // Head word.
    input  wire logic             out_ready  // Pop request.
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr_q;
    logic [AW-1:0]    rptr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;
    logic [AW:0]      count_d;

    // Push and pop qualified by the clock enable so a frozen block moves nothing.
    assign push      = ce && in_valid && in_ready_q;
    assign pop       = ce && out_ready && out_valid;
    assign out_valid = (count_q != '0);
    assign out_data  = mem[rptr_q];
    assign count_d   = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    // Storage array, written without reset.
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wptr_q] <= in_data;
        end
    end

    // Pointers and the registered ready flag.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wptr_q     <= '0;
            rptr_q     <= '0;
            count_q    <= '0;
            in_ready_q <= 1'b0;
        end else if (ce) begin
            if (push) begin
                wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q <= (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
            end
            count_q    <= count_d;
            in_ready_q <= (count_d != (AW+1)'(DEPTH));
        end
    end
endmodule : sample_fifo

// Link configuration registers and frame assembly for one lane.
module link_tx_framer import link_tx_pkg::*; #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic     sys_clk,      // System clock, 10 MHz.
    input  wire logic     srst,         // Synchronous reset, active high.
    input  wire logic     ce,           // Clock enable, freezes all state when low.
    input  wire reg_req_t reg_req,      // Register access request.
    output logic [7:0]    reg_rdata_q,  // Register read data.
    input  wire logic     sample_valid, // Converter sample offered.
    input  wire sample_t  sample_in,    // Converter sample and control bits.
    output logic          sample_ready, // Sample accepted this cycle when valid.
    input  wire logic     sync_n_pin,   // Receiver sync request, active low.
    output logic [7:0]    tx_octet_q,   // Octet to the line coder.
    output logic          tx_is_k_q,    // Octet is a control character.
    output logic          tx_active_q   // Lane is transmitting.
);
    logic [7:0]  fmt_q;
    logic [7:0]  lane_q;
    logic [7:0]  did_q;
    logic [3:0]  bid_q;
    logic [4:0]  lid_q;
    logic        scr_q;
    logic [7:0]  k_q;
    logic [1:0]  cs_q;
    // Snapshot of the link settings used by the running lane.
    logic [7:0]  c_did_q;
    logic [3:0]  c_bid_q;
    logic [4:0]  c_lid_q;
    logic        c_scr_q;
    logic [4:0]  c_k_q;
    logic [1:0]  c_cs_q;
    logic [1:0]  c_ilas_q;
    logic [7:0]  fchk;
    logic        sync_meta_q;
    logic        sync_q;
    phase_t      phase_q;
    logic [5:0]  cnt_q;
    logic [1:0]  mf_q;
    logic [5:0]  kf_last;
    logic        mf_end;
    logic [14:0] scr_state_q;
    logic [14:0] prn_q;
    logic [7:0]  prev_last_q;
    logic [7:0]  lo_q;
    logic        fifo_valid;
    sample_t     fifo_head;
    logic        fifo_pop;
    logic [15:0] word;
    logic [7:0]  raw;
    logic [22:0] scr_res;
    logic [7:0]  oct_d;
    logic        k_d;
    logic        lane_dis;

    assign lane_dis = lane_q[LANE_DIS_BIT];

    // Incoming samples queue here; the framer only drains in the data phase.
    sample_fifo #(
        .WIDTH ($bits(sample_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk    (sys_clk),
        .srst       (srst),
        .ce         (ce),
        .in_valid   (sample_valid),
        .in_data    (sample_in),
        .in_ready_q (sample_ready),
        .out_valid  (fifo_valid),
        .out_data   (fifo_head),
        .out_ready  (fifo_pop)
    );

    // Self-synchronising scrambler 1 + x^14 + x^15, eight bits MSB first.
    function automatic logic [22:0] scramble(input logic [7:0] d, input logic [14:0] s);
        logic [14:0] st;
        logic [7:0]  o;
        logic        b;
        st = s;
        o  = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            b    = d[i] ^ st[13] ^ st[14];
            o[i] = b;
            st   = {st[13:0], b};
        end
        return {st, o};
    endfunction : scramble

    // Software-writable registers; read-only fields ignore writes.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            fmt_q  <= RST_FMT;
            lane_q <= RST_LANE;
            did_q  <= RST_DID;
            bid_q  <= RST_BID;
            lid_q  <= RST_LID;
            scr_q  <= RST_SCR;
            k_q    <= RST_K;
            cs_q   <= RST_CS;
        end else if (ce && reg_req.wr) begin
            case (reg_req.addr)
                ADDR_FMT:  fmt_q  <= reg_req.wdata;
                ADDR_LANE: lane_q <= reg_req.wdata;
                ADDR_DID:  did_q  <= reg_req.wdata;
                ADDR_BID:  bid_q  <= reg_req.wdata[3:0];
                ADDR_LID:  lid_q  <= reg_req.wdata[4:0];
                ADDR_SCR:  scr_q  <= reg_req.wdata[SCR_BIT];
                ADDR_K:    k_q    <= reg_req.wdata;
                ADDR_CSN:  cs_q   <= reg_req.wdata[CS_LSB +: 2];
                default: ;
            endcase
        end
    end

    // Settings are captured only while the lane is held off, so a change made
    // with the lane running cannot tear a multiframe in progress.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            c_did_q  <= RST_DID;
            c_bid_q  <= RST_BID;
            c_lid_q  <= RST_LID;
            c_scr_q  <= RST_SCR;
            c_k_q    <= RST_K[4:0];
            c_cs_q   <= RST_CS;
            c_ilas_q <= ILAS_ON;
        end else if (ce && phase_q == PH_OFF) begin
            c_did_q  <= did_q;
            c_bid_q  <= bid_q;
            c_lid_q  <= lid_q;
            c_scr_q  <= scr_q;
            c_k_q    <= k_q[4:0];
            c_cs_q   <= cs_q;
            c_ilas_q <= lane_q[ILAS_LSB +: 2];
        end
    end

    // Checksum over the unpacked fields, wrapping at eight bits.
    assign fchk = c_did_q + {4'h0, c_bid_q} + {3'h0, c_lid_q} + {7'h00, c_scr_q}
                + (L_VAL - 8'h01) + (F_VAL - 8'h01) + {3'h0, c_k_q} + (M_VAL - 8'h01)
                + {6'h00, c_cs_q} + (N_VAL - 8'h01) + SUBCLASS + NP_ENC + JESDV
                + (S_VAL - 8'h01) + HD_VAL + CF_VAL;

    // Register read port; unmapped addresses read zero.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata_q <= 8'h00;
        end else if (ce && reg_req.rd) begin
            case (reg_req.addr)
                ADDR_FMT:  reg_rdata_q <= fmt_q;
                ADDR_LANE: reg_rdata_q <= lane_q;
                ADDR_DID:  reg_rdata_q <= did_q;
                ADDR_BID:  reg_rdata_q <= {4'h0, bid_q};
                ADDR_LID:  reg_rdata_q <= {3'h0, lid_q};
                ADDR_SCR:  reg_rdata_q <= {scr_q, 2'b00, L_VAL[4:0]};
                ADDR_F:    reg_rdata_q <= F_VAL;
                ADDR_K:    reg_rdata_q <= k_q;
                ADDR_M:    reg_rdata_q <= M_VAL;
                ADDR_CSN:  reg_rdata_q <= {cs_q, 2'b00, N_VAL[3:0]};
                ADDR_NP:   reg_rdata_q <= {4'h0, NP_ENC[3:0]};
                ADDR_S:    reg_rdata_q <= {3'h0, S_VAL[4:0]};
                ADDR_HDCF: reg_rdata_q <= {HD_VAL[0], 2'b00, CF_VAL[4:0]};
                ADDR_FCHK: reg_rdata_q <= fchk;
                default:   reg_rdata_q <= 8'h00;
            endcase
        end
    end

    // The sync request comes from another device and is resynchronised first.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync_meta_q <= 1'b0;
            sync_q      <= 1'b0;
        end else if (ce) begin
            sync_meta_q <= sync_n_pin;
            sync_q      <= sync_meta_q;
        end
    end

    // Free-running pseudo-random source for fill and tail bits.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prn_q <= PRN_SEED;
        end else if (ce) begin
            prn_q <= {prn_q[13:0], prn_q[13] ^ prn_q[14]};
        end
    end

    // Multiframe length is K frames of two octets, so the last index is 2K-1.
    assign kf_last = {c_k_q, 1'b1};
    assign mf_end  = (cnt_q == kf_last);

    // Phase sequencing: off, code group sync, ILAS, data.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            phase_q <= PH_OFF;
            cnt_q   <= '0;
            mf_q    <= '0;
        end else if (ce) begin
            cnt_q <= mf_end ? 6'h00 : cnt_q + 6'h01;
            if (lane_dis) begin
                phase_q <= PH_OFF;
                cnt_q   <= '0;
            end else if (phase_q == PH_OFF) begin
                phase_q <= PH_CGS;
                cnt_q   <= '0;
            end else if (!sync_q) begin
                phase_q <= PH_CGS;
            end else if (mf_end) begin
                case (phase_q)
                    PH_CGS: begin
                        mf_q    <= '0;
                        phase_q <= (c_ilas_q == ILAS_OFF) ? PH_DATA : PH_ILAS;
                    end
                    PH_ILAS: begin
                        mf_q <= mf_q + 2'h1;
                        if (mf_q == 2'(ILAS_MFS - 1) && c_ilas_q != ILAS_REPEAT) begin
                            phase_q <= PH_DATA;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Sample word: 11 data bits, three fill bits, two tail or control bits.
    always_comb begin
        word = 16'h0000;
        if (fifo_valid) begin
            word[15:5] = fifo_head.data;
            word[4:2]  = lane_q[LANE_RAND_BIT] ? prn_q[2:0] : fmt_q[FILL_LSB +: 3];
            word[1:0]  = lane_q[LANE_RAND_BIT] ? prn_q[4:3] : 2'b00;
            case (c_cs_q)
                2'h1:    word[1] = fifo_head.ctrl[1];
                2'h2:    word[1:0] = fifo_head.ctrl;
                2'h3:    word[1:0] = fifo_head.ctrl;
                default: ;
            endcase
        end
    end

    // One sample is taken per frame, on its first octet; an empty queue sends zeros.
    assign fifo_pop = (phase_q == PH_DATA) && !cnt_q[0];
    assign raw      = cnt_q[0] ? lo_q : word[15:8];
    assign scr_res  = scramble(raw, scr_state_q);

    // Next output octet for the current phase and position.
    always_comb begin
        oct_d = 8'h00;
        k_d   = 1'b0;
        case (phase_q)
            PH_CGS: begin
                oct_d = K28_5;
                k_d   = 1'b1;
            end
            PH_ILAS: begin
                oct_d = {2'b00, cnt_q};
                if (cnt_q == 6'h00) begin
                    oct_d = K28_0;
                    k_d   = 1'b1;
                end else if (mf_end) begin
                    oct_d = K28_3;
                    k_d   = 1'b1;
                end else if (mf_q == 2'h1 && cnt_q == 6'h01) begin
                    oct_d = K28_4;
                    k_d   = 1'b1;
                end else if (mf_q == 2'h1 && cnt_q < 6'(CFG_OCTETS + 2)) begin
                    case (cnt_q - 6'h02)
                        6'd0:    oct_d = c_did_q;
                        6'd1:    oct_d = {4'h0, c_bid_q};
                        6'd2:    oct_d = {3'h0, c_lid_q};
                        6'd3:    oct_d = {c_scr_q, 2'b00, 5'(L_VAL - 8'h01)};
                        6'd4:    oct_d = F_VAL - 8'h01;
                        6'd5:    oct_d = {3'h0, c_k_q};
                        6'd6:    oct_d = M_VAL - 8'h01;
                        6'd7:    oct_d = {c_cs_q, 1'b0, 5'(N_VAL - 8'h01)};
                        6'd8:    oct_d = {SUBCLASS[2:0], NP_ENC[4:0]};
                        6'd9:    oct_d = {JESDV[2:0], 5'(S_VAL - 8'h01)};
                        6'd10:   oct_d = {HD_VAL[0], 2'b00, CF_VAL[4:0]};
                        6'd13:   oct_d = fchk;
                        default: oct_d = 8'h00;
                    endcase
                end
            end
            PH_DATA: begin
                if (c_scr_q) begin
                    oct_d = scr_res[7:0];
                    if (mf_end && oct_d == K28_3) begin
                        k_d = 1'b1;
                    end else if (cnt_q[0] && !mf_end && oct_d == K28_7) begin
                        k_d = 1'b1;
                    end
                end else begin
                    oct_d = raw;
                    if (cnt_q[0] && raw == prev_last_q) begin
                        oct_d = mf_end ? K28_3 : K28_7;
                        k_d   = 1'b1;
                    end
                end
            end
            default: ;
        endcase
    end

    // Data-path state: scrambler history, second octet and last frame octet.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            scr_state_q <= '0;
            lo_q        <= 8'h00;
            prev_last_q <= 8'h00;
        end else if (ce) begin
            if (phase_q != PH_DATA) begin
                scr_state_q <= '0;
            end else begin
                scr_state_q <= scr_res[22:8];
                if (!cnt_q[0]) begin
                    lo_q <= word[7:0];
                end else begin
                    prev_last_q <= raw;
                end
            end
        end
    end

    // Registered line outputs; a disabled lane sends nothing.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_octet_q  <= 8'h00;
            tx_is_k_q   <= 1'b0;
            tx_active_q <= 1'b0;
        end else if (ce) begin
            // The phase lags the disable bit by one cycle, so gate on the bit itself.
            tx_octet_q  <= lane_dis ? 8'h00 : oct_d;
            tx_is_k_q   <= k_d && !lane_dis;
            tx_active_q <= (phase_q != PH_OFF) && !lane_dis;
        end
    end

endmodule : link_tx_framer

// >>> verif/link_tx_framer_checker.sv
`timescale 1ns/1ps
// Port checks of the framer; each window counts from the edge that takes the request.
module link_tx_framer_checker import link_tx_pkg::*; #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic       sys_clk,     // Clock.
    input wire logic       srst,        // Reset.
    input wire logic       ce,          // Enable.
    input wire reg_req_t   reg_req,     // Register request.
    input wire logic [7:0] reg_rdata_q, // Read data.
    input wire logic [7:0] tx_octet_q,  // Line octet.
    input wire logic       tx_is_k_q,   // Control flag.
    input wire logic       tx_active_q  // Lane running.
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Helper flags keep the property lines short.
    wire k_ok   = tx_octet_q inside {K28_0, K28_3, K28_4, K28_5, K28_7};
    wire q_char = tx_is_k_q && tx_octet_q == K28_4;
    // A lane control write that sets or clears the disable bit.
    sequence lane_wr(logic off);
        ce && reg_req.wr && reg_req.addr == ADDR_LANE && reg_req.wdata[0] == off;
    endsequence
    // A read taken at this edge.
    sequence rd_of(logic [7:0] a);
        ce && reg_req.rd && reg_req.addr == a;
    endsequence
    // The first octet of a fresh start is a comma.
    sequence comma;
        tx_active_q && tx_is_k_q && tx_octet_q == K28_5;
    endsequence
    off_quiet_a: assert property (!tx_active_q |-> tx_octet_q == 8'h00 && !tx_is_k_q)
        else $error("idle lane drives the line");
    lane_stop_a: assert property (lane_wr(1'b1) |-> ##[1:3] !tx_active_q)
        else $error("lane still active after disable");
    lane_start_a: assert property (!tx_active_q ##0 lane_wr(1'b0) |-> ##[1:4] comma)
        else $error("no comma after enable");
    f_read_a: assert property (rd_of(ADDR_F) |=> reg_rdata_q == F_VAL)
        else $error("octets per frame misreported");
    m_read_a: assert property (rd_of(ADDR_M) |=> reg_rdata_q == M_VAL)
        else $error("converter count misreported");
    np_read_a: assert property (rd_of(ADDR_NP) |=> reg_rdata_q[3:0] == NP_ENC[3:0])
        else $error("sample width misreported");
    k_char_a: assert property (tx_is_k_q |-> k_ok)
        else $error("unknown control character");
    r_then_q_a: assert property (q_char |-> $past(tx_is_k_q) && $past(tx_octet_q) == K28_0)
        else $error("second multiframe start out of order");
endmodule : link_tx_framer_checker

// >>> verif/link_rx_model.sv
`timescale 1ns/1ps
// Receiver stand-in: holds its sync request until a short run of commas is seen.
module link_rx_model import link_tx_pkg::*; (
    input  wire logic       sys_clk,     // Clock.
    input  wire logic       tx_active_q, // Lane running.
    input  wire logic [7:0] tx_octet_q,  // Line octet.
    input  wire logic       tx_is_k_q,   // Control flag.
    output logic            sync_n_pin   // Sync request, low.
);
    int run = 0;
    initial sync_n_pin = 1'b0;
    // Counting commas first stops the model from releasing on a stray one.
    always @(posedge sys_clk) begin
        if (!tx_active_q) run <= 0;
        else if (tx_is_k_q && tx_octet_q == K28_5) run <= run + 1;
        sync_n_pin <= tx_active_q && run >= 4;
    end
endmodule : link_rx_model

// >>> verif/link_tx_framer_tb.sv
`timescale 1ns/1ps
// Bench: register traffic, three lane start-ups and a queue model of the data frames.
module link_tx_framer_tb import link_tx_pkg::*; ;
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        ce = 1'b1;
    logic        sample_valid = 1'b0;
    logic        taken = 1'b1;
    reg_req_t    reg_req = '0;
    sample_t     sample_in = '0;
    sample_t     q[$];
    logic [7:0]  reg_rdata_q, tx_octet_q;
    logic        sample_ready, sync_n_pin, tx_is_k_q, tx_active_q;
    int          fails = 0;
    int          cmp_count = 0;
    logic [15:0] rst_tab[14] = '{16'h1400, 16'h5F00, 16'h6400, 16'h6500, 16'h6700, 16'h6E81,
        16'h6F02, 16'h701F, 16'h7101, 16'h720B, 16'h730F, 16'h7401, 16'h7500, 16'h0100};
    wire  [8:0]  line = {tx_is_k_q, tx_octet_q};

    always #50 sys_clk = ~sys_clk;

    link_tx_framer #(.FIFO_DEPTH(8)) link_tx_framer_i (.sys_clk, .srst, .ce, .reg_req,
        .reg_rdata_q, .sample_valid, .sample_in, .sample_ready, .sync_n_pin, .tx_octet_q,
        .tx_is_k_q, .tx_active_q);
    link_rx_model link_rx_model_i (.sys_clk, .tx_active_q, .tx_octet_q, .tx_is_k_q, .sync_n_pin);

    // Every accepted sample joins the queue that the frame model draws from.
    always @(posedge sys_clk) begin
        if (!srst && ce && sample_valid && sample_ready) begin
            q.push_back(sample_in);
            taken <= 1'b1;
        end
    end
    // A new sample is offered only once the last was taken; few low bits force repeats.
    always @(negedge sys_clk) begin
        if (taken) begin
            sample_in <= '{2'($urandom), {8'hA5, 3'($urandom % 2)}};
            taken <= 1'b0;
        end
    end

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: register %h not %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_oct(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: octet %h not %h", $time, got, exp);
        end
    endtask : chk_oct

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk) reg_req = '{1'b1, 1'b0, a, d};
        @(negedge sys_clk) reg_req = '0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk) reg_req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge sys_clk) reg_req = '0;
        @(negedge sys_clk) d = reg_rdata_q;
    endtask : reg_rd

    task automatic wait_line(input logic [8:0] v);
        int n;
        n = 0;
        while (line !== v) begin
            @(negedge sys_clk);
            n++;
            if (n > 3000) begin
                fails++;
                $display("wrong value at %0t: line never showed %h", $time, v);
                conclude();
            end
        end
    endtask : wait_line

    // One lane start-up; settings only take hold at the next enable.
    task automatic run_link(input logic scr, input int k, input logic [7:0] device_identifier, bank_identifier, lane_identifier);
        logic [7:0] d, o1, prev;
        logic [7:0] cfg[14];
        logic [8:0] e;
        sample_t    s;
        int         sum;
        reg_wr(ADDR_LANE, 8'h01);
        reg_wr(ADDR_DID, device_identifier);
        reg_wr(ADDR_BID, bank_identifier);
        reg_wr(ADDR_LID, lane_identifier);
        reg_wr(ADDR_SCR, {scr, 7'h00});
        reg_wr(ADDR_K, 8'(k - 1));
        reg_wr(ADDR_FMT, 8'hA0);
        reg_wr(ADDR_CSN, 8'h80);
        sample_valid = !scr;
        reg_rd(ADDR_BID, d);
        chk_reg(d, {4'h0, bank_identifier[3:0]});
        repeat (16) @(negedge sys_clk);
        chk_oct(line, 9'h000);
        chk_reg({7'h00, sample_ready}, {7'h00, scr});
        sum = device_identifier + bank_identifier[3:0] + lane_identifier[4:0] + scr + 1 + (k - 1) + 2 + 10 + 1 + 15 + 1;
        cfg = '{device_identifier, {4'h0, bank_identifier[3:0]}, {3'h0, lane_identifier[4:0]}, {scr, 7'h00}, 8'h01, 8'(k - 1),
            8'h00, 8'h8A, 8'h2F, 8'h20, 8'h00, 8'h00, 8'h00, 8'(sum)};
        reg_wr(ADDR_LANE, 8'h00);
        wait_line({1'b1, K28_4});
        for (int i = 0; i < 14; i++) begin
            @(negedge sys_clk);
            if (i < 11 || i == 13) chk_oct(line, {1'b0, cfg[i]});
        end
        reg_rd(ADDR_FCHK, d);
        chk_reg(d, 8'(sum));
        if (!scr) begin
            wait_line({1'b0, 8'hA5});
            prev = 8'h00;
            for (int f = 0; f < 4 * k; f++) begin
                s = q.pop_front();
                o1 = {s.data[2:0], 3'b101, s.ctrl};
                chk_oct(line, {1'b0, s.data[10:3]});
                @(negedge sys_clk);
                e = {1'b0, o1};
                if (o1 == prev) e = {1'b1, (f % k == k - 1) ? K28_3 : K28_7};
                if (f > 0) chk_oct(line, e);
                prev = o1;
                @(negedge sys_clk);
            end
            sample_valid = 1'b0;
            wait_line(9'h000);
            chk_reg({7'h00, sample_ready}, 8'h01);
        end
    endtask : run_link

    // Main sequence: reset values, a refused write, then three start-ups.
    initial begin
        logic [7:0] d;
        logic [8:0] e;
        int         n;
        void'($urandom(93555));
        repeat (20) @(negedge sys_clk);
        srst = 1'b0;
        foreach (rst_tab[i]) begin
            reg_rd(rst_tab[i][15:8], d);
            chk_reg(d, rst_tab[i][7:0]);
        end
        reg_wr(ADDR_F, 8'hFF);
        reg_rd(ADDR_F, d);
        chk_reg(d, F_VAL);
        run_link(1'b1, 32, 8'($urandom), 8'($urandom), 8'($urandom));
        run_link(1'b0, 12, 8'($urandom), 8'($urandom), 8'($urandom));
        // ILAS off: commas must lead straight to frames, with no configuration marker.
        reg_wr(ADDR_LANE, 8'h01);
        reg_wr(ADDR_LANE, 8'h04);
        n = 0;
        e = 9'h000;
        while (line !== {1'b1, K28_7} && n < 3000) begin
            if (line == {1'b1, K28_4}) e = line;
            @(negedge sys_clk);
            n++;
        end
        chk_oct(e, 9'h000);
        chk_oct(line, {1'b1, K28_7});
        conclude();
    end
endmodule : link_tx_framer_tb

bind link_tx_framer link_tx_framer_checker #(.FIFO_DEPTH(FIFO_DEPTH)) link_tx_framer_checker_i (
    .sys_clk, .srst, .ce, .reg_req, .reg_rdata_q, .tx_octet_q, .tx_is_k_q, .tx_active_q);
